// >>> hw/nvc_consts.svh
`ifndef NVC_CONSTS_SVH
`define NVC_CONSTS_SVH

// bus widths of the memory pins and the timer width
`define NVC_ADDR_W 17
`define NVC_DATA_W 16
`define NVC_TMR_W 20

// clock and times in their own units
`define NVC_CLK_PERIOD_NS 100
`define NVC_ACCESS_NS 100
`define NVC_STORE_REQUEST_DELAY_NS 25000
`define NVC_BUSY_RELEASE_DRIVE_NS 500
`define NVC_SAVE_CYCLE_US 8000
`define NVC_SW_RESTORE_US 200
`define NVC_POWERUP_RESTORE_US 20000

// least times round up to whole clock cycles
`define NVC_CYC_UP(ns) (((ns) + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)

// software mode address sequence
`define NVC_SEQ_LAST 5
`define NVC_SEQ_A0 16'h4E38
`define NVC_SEQ_A1 16'hB1C7
`define NVC_SEQ_A2 16'h83E0
`define NVC_SEQ_A3 16'h7C1F
`define NVC_SEQ_A4 16'h703F
`define NVC_SEQ_SAVE 16'h8FC0
`define NVC_SEQ_RESTORE 16'h4C63
`define NVC_SEQ_PLS_OFF 16'h8B45
`define NVC_SEQ_PLS_ON 16'h4B46

`endif

// >>> hw/nvc_ctrl.sv
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_ctrl #(
   parameter int ACCESS_CYC  = `NVC_CYC_UP(`NVC_ACCESS_NS),
   parameter int DELAY_CYC   = `NVC_CYC_UP(`NVC_STORE_REQUEST_DELAY_NS),
   parameter int RELEASE_CYC = `NVC_CYC_UP(`NVC_BUSY_RELEASE_DRIVE_NS),
   parameter int SAVE_CYC    = `NVC_CYC_UP(`NVC_SAVE_CYCLE_US * 1000),
   parameter int RESTORE_CYC = `NVC_CYC_UP(`NVC_SW_RESTORE_US * 1000),
   parameter int POWERUP_CYC = `NVC_CYC_UP(`NVC_POWERUP_RESTORE_US * 1000)
) (
   input  wire logic                   CLOCK,
   input  wire logic                   RSTN,
   input  wire logic                   CMD_VALID,
   input  nvc_pkg::nvc_cmd_type        CMD,
   output logic                        CMD_READY,
   output logic                        RSP_VALID,
   output logic [`NVC_DATA_W-1:0]      RSP_RDATA,
   output logic                        NV_ACTIVE,
   output logic [`NVC_ADDR_W-1:0]      ADDR,
   output logic                        CHIP_ENABLE_N,
   output logic                        WRITE_ENABLE_N,
   output logic                        OUTPUT_ENABLE_N,
   output logic                        UPPER_BYTE_SELECT_N,
   output logic                        LOWER_BYTE_SELECT_N,
   input  wire logic [`NVC_DATA_W-1:0] DQ_IN,
   output logic [`NVC_DATA_W-1:0]      DQ_OUT,
   output logic                        DQ_OE,
   input  wire logic                   STORE_BUSY_LINE_IN,
   output logic                        STORE_BUSY_LINE_OUT,
   output logic                        STORE_BUSY_LINE_OE
);
   localparam int TW = `NVC_TMR_W;

   // refuse zero counts, and delay, save, restore and power-up counts the timer cannot hold
   if (ACCESS_CYC < 1 || DELAY_CYC < 1 || RELEASE_CYC < 1 || SAVE_CYC < 1 ||
       RESTORE_CYC < 1 || POWERUP_CYC < 1 || SAVE_CYC >= 2**TW ||
       RESTORE_CYC >= 2**TW || POWERUP_CYC >= 2**TW || DELAY_CYC >= 2**TW) begin : g_bad
      $error("nvc_ctrl: timing count out of range");
   end

   nvc_pkg::nvc_state_type  state_q, state_d;
   nvc_pkg::nvc_op_type     seq_op_q;
   logic                    seq_q, chain_q, is_write_q;
   logic [2:0]              seq_idx_q;
   logic                    tmr_load, tmr_done;
   logic [TW-1:0]           tmr_value;
   logic [1:0]              be_q;
   logic                    busy_in;
   logic [TW-1:0]           pull_cnt_q;

   assign busy_in = STORE_BUSY_LINE_IN;

   // sequence address for a step; only bits 14..2 matter to the device
   function automatic logic [15:0] seq_addr(input nvc_pkg::nvc_op_type op,
                                            input logic [2:0] idx);
      logic [15:0] a;
      a = `NVC_SEQ_SAVE;
      case (idx)
         3'h0: a = `NVC_SEQ_A0;
         3'h1: a = `NVC_SEQ_A1;
         3'h2: a = `NVC_SEQ_A2;
         3'h3: a = `NVC_SEQ_A3;
         3'h4: a = `NVC_SEQ_A4;
         default: begin
            case (op)
               nvc_pkg::OP_SW_RESTORE: a = `NVC_SEQ_RESTORE;
               nvc_pkg::OP_PLS_OFF:    a = `NVC_SEQ_PLS_OFF;
               nvc_pkg::OP_PLS_ON:     a = `NVC_SEQ_PLS_ON;
               default:                a = `NVC_SEQ_SAVE;
            endcase
         end
      endcase
      return a;
   endfunction

   function automatic logic is_seq_op(input nvc_pkg::nvc_op_type op);
      return op inside {nvc_pkg::OP_SW_SAVE, nvc_pkg::OP_SW_RESTORE,
                        nvc_pkg::OP_PLS_OFF, nvc_pkg::OP_PLS_ON};
   endfunction

   nvc_timer #(
      .W         (TW),
      .RST_COUNT (POWERUP_CYC)
   ) u_tmr (
      .clk   (CLOCK),
      .rst_n (RSTN),
      .load  (tmr_load),
      .value (tmr_value),
      .done  (tmr_done)
   );

   // sequencer next state and timer loads
   always_comb begin
      state_d   = state_q;
      tmr_load  = 1'b0;
      tmr_value = '0;
      case (state_q)
         nvc_pkg::ST_INIT: begin
            if (tmr_done && busy_in) state_d = nvc_pkg::ST_IDLE;
         end
         nvc_pkg::ST_IDLE: begin
            if (CMD_VALID && CMD_READY) begin
               if (CMD.op == nvc_pkg::OP_HW_SAVE) begin
                  state_d   = nvc_pkg::ST_HW_PULL;
                  tmr_load  = 1'b1;
                  tmr_value = TW'(DELAY_CYC);
               end else begin
                  state_d   = nvc_pkg::ST_SETUP;
               end
            end
         end
         nvc_pkg::ST_SETUP: begin
            // a low line blocks every access, whoever holds it
            if (busy_in) begin
               state_d   = nvc_pkg::ST_STROBE;
               tmr_load  = 1'b1;
               tmr_value = TW'(ACCESS_CYC);
            end
         end
         nvc_pkg::ST_STROBE: begin
            if (tmr_done) state_d = nvc_pkg::ST_RECOVER;
         end
         nvc_pkg::ST_RECOVER: begin
            if (seq_q && seq_idx_q == 3'(`NVC_SEQ_LAST)) begin
               state_d   = nvc_pkg::ST_NV_WAIT;
               tmr_load  = 1'b1;
               if (seq_op_q == nvc_pkg::OP_SW_SAVE)
                  tmr_value = TW'(SAVE_CYC);
               else if (seq_op_q == nvc_pkg::OP_SW_RESTORE)
                  tmr_value = TW'(RESTORE_CYC);
               else
                  tmr_value = TW'(RELEASE_CYC);
            end else if (seq_q) begin
               state_d = nvc_pkg::ST_SETUP;
            end else begin
               state_d = nvc_pkg::ST_IDLE;
            end
         end
         nvc_pkg::ST_HW_PULL: begin
            if (tmr_done) begin
               state_d   = nvc_pkg::ST_HW_WAIT;
               tmr_load  = 1'b1;
               tmr_value = TW'(RELEASE_CYC);
            end
         end
         nvc_pkg::ST_HW_WAIT: begin
            // line may never go low when no write is pending
            if (tmr_done && busy_in) state_d = nvc_pkg::ST_IDLE;
         end
         nvc_pkg::ST_NV_WAIT: begin
            if (tmr_done && busy_in)
               state_d = chain_q ? nvc_pkg::ST_SETUP : nvc_pkg::ST_IDLE;
         end
         default: state_d = nvc_pkg::ST_IDLE;
      endcase
   end

   // state register and ready flag
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_q   <= nvc_pkg::ST_INIT;
         CMD_READY <= 1'b0;
         NV_ACTIVE <= 1'b1;
      end else begin
         state_q   <= state_d;
         CMD_READY <= (state_d == nvc_pkg::ST_IDLE);
         NV_ACTIVE <= state_d inside {nvc_pkg::ST_INIT, nvc_pkg::ST_HW_PULL,
                                      nvc_pkg::ST_HW_WAIT, nvc_pkg::ST_NV_WAIT};
      end
   end

   // access target and sequence tracking
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         seq_q      <= 1'b0;
         chain_q    <= 1'b0;
         is_write_q <= 1'b0;
         seq_idx_q  <= 3'h0;
         seq_op_q   <= nvc_pkg::OP_READ;
         ADDR       <= '0;
         DQ_OUT     <= '0;
         be_q       <= 2'h0;
      end else if (state_q == nvc_pkg::ST_IDLE && CMD_VALID && CMD_READY) begin
         seq_q      <= is_seq_op(CMD.op);
         chain_q    <= CMD.op inside {nvc_pkg::OP_PLS_OFF, nvc_pkg::OP_PLS_ON};
         is_write_q <= (CMD.op == nvc_pkg::OP_WRITE);
         seq_idx_q  <= 3'h0;
         seq_op_q   <= CMD.op;
         ADDR       <= is_seq_op(CMD.op) ? `NVC_ADDR_W'(seq_addr(CMD.op, 3'h0)) : CMD.addr;
         DQ_OUT     <= CMD.wdata;
         be_q       <= is_seq_op(CMD.op) ? 2'h3 : CMD.be;
      end else if (state_q == nvc_pkg::ST_RECOVER && seq_q &&
                   seq_idx_q != 3'(`NVC_SEQ_LAST)) begin
         seq_idx_q  <= seq_idx_q + 3'h1;
         ADDR       <= `NVC_ADDR_W'(seq_addr(seq_op_q, seq_idx_q + 3'h1));
      end else if (state_q == nvc_pkg::ST_NV_WAIT && state_d == nvc_pkg::ST_SETUP) begin
         // setting change is made permanent by an unconditional save
         chain_q    <= 1'b0;
         seq_idx_q  <= 3'h0;
         seq_op_q   <= nvc_pkg::OP_SW_SAVE;
         ADDR       <= `NVC_ADDR_W'(seq_addr(nvc_pkg::OP_SW_SAVE, 3'h0));
      end else if (state_q == nvc_pkg::ST_NV_WAIT && state_d == nvc_pkg::ST_IDLE) begin
         seq_q      <= 1'b0;
      end
   end

   // memory strobes; sequence reads are chip-enable reads, write strobe high
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         CHIP_ENABLE_N       <= 1'b1;
         WRITE_ENABLE_N      <= 1'b1;
         OUTPUT_ENABLE_N     <= 1'b1;
         UPPER_BYTE_SELECT_N <= 1'b1;
         LOWER_BYTE_SELECT_N <= 1'b1;
         DQ_OE               <= 1'b0;
      end else if (state_q == nvc_pkg::ST_SETUP && state_d == nvc_pkg::ST_STROBE) begin
         CHIP_ENABLE_N       <= 1'b0;
         WRITE_ENABLE_N      <= ~(is_write_q & ~seq_q);
         OUTPUT_ENABLE_N     <= is_write_q & ~seq_q;
         UPPER_BYTE_SELECT_N <= ~be_q[1];
         LOWER_BYTE_SELECT_N <= ~be_q[0];
         DQ_OE               <= is_write_q & ~seq_q;
      end else if (state_q == nvc_pkg::ST_STROBE && tmr_done) begin
         CHIP_ENABLE_N       <= 1'b1;
         WRITE_ENABLE_N      <= 1'b1;
         OUTPUT_ENABLE_N     <= 1'b1;
         UPPER_BYTE_SELECT_N <= 1'b1;
         LOWER_BYTE_SELECT_N <= 1'b1;
         DQ_OE               <= 1'b0;
      end
   end

   // read data capture and completion pulse
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RSP_RDATA <= '0;
         RSP_VALID <= 1'b0;
      end else begin
         if (state_q == nvc_pkg::ST_STROBE && tmr_done && !is_write_q && !seq_q)
            RSP_RDATA <= DQ_IN;
         RSP_VALID <= (state_q == nvc_pkg::ST_RECOVER && !seq_q) ||
                      (state_q != nvc_pkg::ST_INIT && state_q != nvc_pkg::ST_IDLE &&
                       state_q != nvc_pkg::ST_RECOVER && state_d == nvc_pkg::ST_IDLE);
      end
   end

   // open-drain request: only ever drives low
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         STORE_BUSY_LINE_OUT <= 1'b0;
         STORE_BUSY_LINE_OE  <= 1'b0;
      end else begin
         STORE_BUSY_LINE_OUT <= 1'b0;
         STORE_BUSY_LINE_OE  <= (state_d == nvc_pkg::ST_HW_PULL);
      end
   end

   // helper for checking the pull length
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) pull_cnt_q <= '0;
      else if (STORE_BUSY_LINE_OE) pull_cnt_q <= pull_cnt_q + 1'b1;
      else pull_cnt_q <= '0;
   end

   sequence s_pull_end;
      $fell(STORE_BUSY_LINE_OE);
   endsequence

   sequence s_seq_strobe;
      $fell(CHIP_ENABLE_N) && seq_q;
   endsequence

   chk_pull_length: assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_pull_end |-> pull_cnt_q == TW'(DELAY_CYC + 1))
      else $error("request pull length wrong");
   chk_pull_then_idle: assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_pull_end |-> CHIP_ENABLE_N [*2])
      else $error("access right after request release");
   chk_drive_low_only: assert property (@(posedge CLOCK) disable iff (!RSTN)
      STORE_BUSY_LINE_OE |-> !STORE_BUSY_LINE_OUT && CHIP_ENABLE_N)
      else $error("busy line driven high or access during pull");
   chk_access_busy: assert property (@(posedge CLOCK) disable iff (!RSTN)
      $fell(CHIP_ENABLE_N) |-> $past(busy_in))
      else $error("access started while busy line low");
   chk_seq_we_high: assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_seq_strobe |-> WRITE_ENABLE_N && !OUTPUT_ENABLE_N && !DQ_OE)
      else $error("sequence read not a clean read");
   chk_seq_order: assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_seq_strobe |-> ADDR == `NVC_ADDR_W'(seq_addr(seq_op_q, seq_idx_q)))
      else $error("sequence address out of order");
   chk_nv_quiet: assert property (@(posedge CLOCK) disable iff (!RSTN)
      state_q == nvc_pkg::ST_NV_WAIT |-> CHIP_ENABLE_N && !CMD_READY)
      else $error("access during nonvolatile wait");
   chk_chain_save: assert property (@(posedge CLOCK) disable iff (!RSTN)
      state_q == nvc_pkg::ST_NV_WAIT && chain_q && tmr_done && busy_in
      |=> seq_q && seq_op_q == nvc_pkg::OP_SW_SAVE && seq_idx_q == 3'h0)
      else $error("setting change not followed by save");
   chk_init_block: assert property (@(posedge CLOCK) disable iff (!RSTN)
      state_q == nvc_pkg::ST_INIT |-> !CMD_READY && CHIP_ENABLE_N && NV_ACTIVE)
      else $error("access before power-up restore ends");
   chk_dq_write_only: assert property (@(posedge CLOCK) disable iff (!RSTN)
      DQ_OE |-> !WRITE_ENABLE_N && OUTPUT_ENABLE_N)
      else $error("data driven outside a write");
endmodule

// >>> hw/nvc_pkg.sv
`include "nvc_consts.svh"
package nvc_pkg;

   // host commands
   typedef enum logic [2:0] {
      OP_READ       = 3'h0,
      OP_WRITE      = 3'h1,
      OP_HW_SAVE    = 3'h2,
      OP_SW_SAVE    = 3'h3,
      OP_SW_RESTORE = 3'h4,
      OP_PLS_OFF    = 3'h5,
      OP_PLS_ON     = 3'h6
   } nvc_op_type;

   typedef struct packed {
      nvc_op_type                 op;
      logic [`NVC_ADDR_W-1:0]     addr;
      logic [`NVC_DATA_W-1:0]     wdata;
      logic [1:0]                 be;
   } nvc_cmd_type;

   typedef enum logic [7:0] {
      ST_INIT    = 8'h01,
      ST_IDLE    = 8'h02,
      ST_SETUP   = 8'h04,
      ST_STROBE  = 8'h08,
      ST_RECOVER = 8'h10,
      ST_HW_PULL = 8'h20,
      ST_HW_WAIT = 8'h40,
      ST_NV_WAIT = 8'h80
   } nvc_state_type;

endpackage

// >>> hw/nvc_timer.sv
`timescale 1ns/1ps
// down counter; done rises exactly value edges after a load
module nvc_timer #(
   parameter int W         = 20,
   parameter int RST_COUNT = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              done
);
   logic [W-1:0] count_q;

   // the reset count lets the power-up wait run without a load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= W'(RST_COUNT);
         done    <= 1'b0;
      end else if (load) begin
         count_q <= value;
         done    <= 1'b0;
      end else if (count_q != '0) begin
         count_q <= count_q - 1'b1;
         done    <= (count_q == W'(1));
      end else begin
         done    <= 1'b1;
      end
   end
endmodule

// >>> tb/nvc_ctrl_test.sv
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_ctrl_test;
   typedef struct packed {
      logic [2:0]  kind;
      logic [31:0] value;
   } nvc_note_type;

   logic                 CLOCK;
   logic                 RSTN;
   logic                 CMD_VALID;
   nvc_pkg::nvc_cmd_type CMD;
   logic                 CMD_READY, RSP_VALID, nv_active;
   logic [15:0]          RSP_RDATA, dq_out, dq_w, dev_dq, d;
   logic [15:0]          dq_last = 16'h0000;
   logic [16:0]          addr;
   logic                 ce_n, we_n, oe_n, ube_n, lbe_n, dq_oe, bsy_out, bsy_oe;
   logic                 dev_oe, dev_low, dev_high, pls_on, busy_w;
   logic [15:0]          ref_mem [0:7];
   int                   saves, restores, fails, checked, rsp_seen, cycles, seed;
   nvc_note_type         note_q [$];
   nvc_note_type         note;

   // pull-up on the busy line; a released data bus shows a moving pattern
   assign busy_w = ((bsy_oe && !bsy_out) || dev_low) ? 1'b0 : 1'b1;
   assign dq_w   = dq_oe ? dq_out : (dev_oe ? dev_dq : dq_last);
   always @(posedge CLOCK) dq_last <= ~dq_w;

   // access time left at its default of one cycle
   nvc_ctrl #(.DELAY_CYC(3), .RELEASE_CYC(2), .SAVE_CYC(20),
      .RESTORE_CYC(10), .POWERUP_CYC(5)) u_nvc_ctrl (
      .CLOCK(CLOCK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
      .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .NV_ACTIVE(nv_active), .ADDR(addr),
      .CHIP_ENABLE_N(ce_n), .WRITE_ENABLE_N(we_n), .OUTPUT_ENABLE_N(oe_n),
      .UPPER_BYTE_SELECT_N(ube_n), .LOWER_BYTE_SELECT_N(lbe_n), .DQ_IN(dq_w),
      .DQ_OUT(dq_out), .DQ_OE(dq_oe), .STORE_BUSY_LINE_IN(busy_w),
      .STORE_BUSY_LINE_OUT(bsy_out), .STORE_BUSY_LINE_OE(bsy_oe));

   nvc_dev_model u_nvc_dev_model (
      .clk(CLOCK), .addr(addr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .ube_n(ube_n),
      .lbe_n(lbe_n), .dq_i(dq_w), .busy(busy_w), .dq_o(dev_dq), .dq_oe(dev_oe),
      .busy_low(dev_low), .busy_high(dev_high), .saves(saves), .restores(restores),
      .pls_on(pls_on));

   function automatic logic [15:0] seq(input int i);
      case (i)
         0: return `NVC_SEQ_A0;
         1: return `NVC_SEQ_A1;
         2: return `NVC_SEQ_A2;
         3: return `NVC_SEQ_A3;
         default: return `NVC_SEQ_A4;
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checked %0d, fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one command, its expectation queued for the monitor
   task automatic send(input nvc_pkg::nvc_op_type op, input logic [16:0] a,
                       input logic [15:0] wd, input logic [1:0] be, input logic [2:0] kind,
                       input logic [31:0] v);
      int target;
      target = rsp_seen + 1;
      note_q.push_back('{kind, v});
      CMD = '{op: op, addr: a, wdata: wd, be: be};
      CMD_VALID = 1'b1;
      @(posedge CLOCK);
      while (CMD_READY !== 1'b1) @(posedge CLOCK);
      #10 CMD_VALID = 1'b0;
      while (rsp_seen < target) @(posedge CLOCK);
      #10;
   endtask

   initial begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end

   // monitor: oldest note against each response
   always @(posedge CLOCK) begin
      if (RSP_VALID === 1'b1) begin
         rsp_seen++;
         if (note_q.size() == 0) begin
            fails++;
            $display("Error at %0t: response with nothing pending", $time);
         end else begin
            note = note_q.pop_front();
            case (note.kind)
               3'h1: check({16'h0000, RSP_RDATA}, note.value);
               3'h2: check(saves, note.value);
               3'h3: check(restores, note.value);
               3'h4: check({31'h00000000, pls_on}, note.value);
               default: ;
            endcase
         end
      end
   end

   // ceiling well above the several hundred cycles the run needs
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("Error at %0t: run timed out", $time);
         give_verdict();
      end
   end

   initial begin
      seed = 28444;
      RSTN = 1'b0;
      CMD_VALID = 1'b0;
      CMD = '0;
      repeat (3) @(posedge CLOCK);
      #10 RSTN = 1'b1;
      check({31'h0, nv_active}, 32'h1);
      // random words, one byte-lane overwrite, read back
      for (int i = 0; i < 8; i++) begin
         ref_mem[i] = 16'($random(seed));
         send(nvc_pkg::OP_WRITE, 17'h01000 + 17'(i), ref_mem[i], 2'b11, 3'h0, 32'h0);
      end
      d = 16'($random(seed));
      send(nvc_pkg::OP_WRITE, 17'h01003, d, 2'b01, 3'h0, 32'h0);
      ref_mem[3][7:0] = d[7:0];
      for (int i = 0; i < 8; i++)
         send(nvc_pkg::OP_READ, 17'h01000 + 17'(i), 16'h0000, 2'b11, 3'h1, {16'h0, ref_mem[i]});
      send(nvc_pkg::OP_HW_SAVE, 17'h0, 16'h0, 2'b11, 3'h2, 32'h1);
      check({31'h0, nv_active}, 32'h0);
      send(nvc_pkg::OP_HW_SAVE, 17'h0, 16'h0, 2'b11, 3'h2, 32'h1);
      send(nvc_pkg::OP_SW_SAVE, 17'h0, 16'h0, 2'b11, 3'h2, 32'h2);
      send(nvc_pkg::OP_WRITE, 17'h01000, 16'($random(seed)), 2'b11, 3'h0, 32'h0);
      send(nvc_pkg::OP_SW_RESTORE, 17'h0, 16'h0, 2'b11, 3'h3, 32'h1);
      send(nvc_pkg::OP_READ, 17'h01000, 16'h0, 2'b11, 3'h1, {16'h0, ref_mem[0]});
      send(nvc_pkg::OP_PLS_OFF, 17'h0, 16'h0, 2'b11, 3'h4, 32'h0);
      check(saves, 3);
      send(nvc_pkg::OP_PLS_ON, 17'h0, 16'h0, 2'b11, 3'h4, 32'h1);
      check(saves, 4);
      // a write in mid-sequence must abort it
      for (int i = 0; i < 5; i++)
         send(nvc_pkg::OP_READ, {1'b0, seq(i)}, 16'h0, 2'b11, 3'h0, 32'h0);
      send(nvc_pkg::OP_WRITE, 17'h02000, 16'h5A5A, 2'b11, 3'h0, 32'h0);
      send(nvc_pkg::OP_READ, {1'b0, `NVC_SEQ_SAVE}, 16'h0, 2'b11, 3'h0, 32'h0);
      repeat (40) @(posedge CLOCK);
      #10;
      check(saves, 4);
      // outer address bits flipped still match
      for (int i = 0; i < 5; i++)
         send(nvc_pkg::OP_READ, {1'b1, seq(i) ^ 16'h8003}, 16'h0, 2'b11, 3'h0, 32'h0);
      send(nvc_pkg::OP_READ, {1'b1, `NVC_SEQ_SAVE ^ 16'h8003}, 16'h0, 2'b11, 3'h0, 32'h0);
      repeat (40) @(posedge CLOCK);
      check(saves, 5);
      give_verdict();
   end
endmodule

// >>> tb/nvc_dev_model.sv
`timescale 1ns/1ps
`include "nvc_consts.svh"
// behavioural nonvolatile sram, times counted in host clock cycles
module nvc_dev_model #(
   parameter int DELAY_CYC   = 3,
   parameter int RELEASE_CYC = 2,
   parameter int SAVE_CYC    = 18,
   parameter int RESTORE_CYC = 9,
   parameter int POWERUP_CYC = 8
) (
   input  wire logic        clk,
   input  wire logic [16:0] addr,
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic        ube_n,
   input  wire logic        lbe_n,
   input  wire logic [15:0] dq_i,
   input  wire logic        busy,
   output logic [15:0]      dq_o,
   output logic             dq_oe,
   output logic             busy_low,
   output logic             busy_high,
   output int               saves,
   output int               restores,
   output logic             pls_on
);
   logic [15:0] mem [0:65535];
   logic [15:0] nv  [0:65535];
   logic        written;
   logic        nv_busy;
   logic        prev_ce_n;
   int          step;

   // sequence address of each step; only bits two to fourteen count
   function automatic logic [15:0] seq(input int i);
      case (i)
         0: return `NVC_SEQ_A0;
         1: return `NVC_SEQ_A1;
         2: return `NVC_SEQ_A2;
         3: return `NVC_SEQ_A3;
         default: return `NVC_SEQ_A4;
      endcase
   endfunction
   function automatic logic [12:0] key(input logic [15:0] a);
      return a[14:2];
   endfunction

   // output only when selected and no transfer or external hold
   assign dq_oe = !ce_n && !oe_n && we_n && !nv_busy && busy;
   assign dq_o  = mem[addr[15:0]];

   always @(posedge clk) prev_ce_n <= ce_n;

   // byte writes, refused while the busy line is low
   always @(posedge clk) begin
      if (!ce_n && !we_n && !nv_busy && busy) begin
         if (!lbe_n) mem[addr[15:0]][7:0] <= dq_i[7:0];
         if (!ube_n) mem[addr[15:0]][15:8] <= dq_i[15:8];
         written <= 1'b1;
      end
   end

   // nonblocking so the host samples a settled line at each edge
   task automatic run_save();
      busy_low <= 1'b1;
      nv_busy  <= 1'b1;
      repeat (SAVE_CYC) @(posedge clk);
      // erase first, then program from sram
      for (int i = 0; i < 65536; i++) nv[i] = 16'h0000;
      for (int i = 0; i < 65536; i++) nv[i] = mem[i];
      written   <= 1'b0;
      saves++;
      busy_low  <= 1'b0;
      busy_high <= 1'b1;
      repeat (RELEASE_CYC) @(posedge clk);
      busy_high <= 1'b0;
      while (!busy) @(posedge clk);
      nv_busy <= 1'b0;
   endtask

   task automatic run_restore(input int cyc);
      nv_busy <= 1'b1;
      repeat (cyc) @(posedge clk);
      for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
      for (int i = 0; i < 65536; i++) mem[i] = nv[i];
      written <= 1'b0;
      restores++;
      nv_busy <= 1'b0;
   endtask

   // power-up restore, then hardware requests and sequence tracking
   initial begin
      saves = 0;
      pls_on = 1'b1;
      step = 0;
      busy_high = 1'b0;
      busy_low = 1'b1;
      written = 1'b0;
      for (int i = 0; i < 65536; i++) nv[i] = 16'h0000;
      run_restore(POWERUP_CYC);
      restores = 0;
      busy_low <= 1'b0;
      forever begin
         @(posedge clk);
         if (!busy && !busy_low) begin
            repeat (DELAY_CYC) @(posedge clk);
            if (written) run_save();
            else while (!busy) @(posedge clk);
            step = 0;
         end else if (!ce_n && prev_ce_n && !nv_busy) begin
            if (!we_n) step = 0;
            else if (step < 5 && addr[14:2] == key(seq(step))) step++;
            else if (step == 5 && addr[14:2] == key(`NVC_SEQ_SAVE)) begin
               step = 0;
               run_save();
            end else if (step == 5 && addr[14:2] == key(`NVC_SEQ_RESTORE)) begin
               step = 0;
               run_restore(RESTORE_CYC);
            end else if (step == 5 && addr[14:2] == key(`NVC_SEQ_PLS_OFF)) begin
               step = 0;
               pls_on = 1'b0;
            end else if (step == 5 && addr[14:2] == key(`NVC_SEQ_PLS_ON)) begin
               step = 0;
               pls_on = 1'b1;
            end else step = (addr[14:2] == key(seq(0))) ? 1 : 0;
         end
      end
   end
endmodule
